// >>> pkg/vcs_pkg.sv
// constants and types shared by the voltage conversion scheduler
`default_nettype none
package vcs_pkg;
  localparam int unsigned CLOCK_NS       = 10;      // core clock period
  localparam int unsigned STEP_BASE_NS   = 1000;    // shortest acquisition window
  localparam int unsigned STEP_BASE_CYC  = (STEP_BASE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int unsigned CYCLE_UNIT_US  = 1000;    // one period timer tick
  localparam int unsigned CYCLE_UNIT_CYC = (CYCLE_UNIT_US * 1000) / CLOCK_NS;
  localparam int unsigned NUM_STEPS      = 7;
  localparam int unsigned FILTER_W       = 3;
  localparam int unsigned PERIOD_W       = 8;
  localparam int unsigned COUNT_W        = 16;
  localparam int unsigned PER_W          = 4;
  localparam int unsigned WIN_W          = 16;
  localparam int unsigned PRE_W          = 24;
  // step order inside one routine run
  localparam logic [2:0] STEP_CELL       = 3'h0;
  localparam logic [2:0] STEP_STACK      = 3'h1;
  localparam logic [2:0] STEP_AUX_CONV   = 3'h2;
  localparam logic [2:0] STEP_AUX_TERM   = 3'h3;
  localparam logic [2:0] STEP_CELL_TERM  = 3'h4;
  localparam logic [2:0] STEP_BAL_TERM   = 3'h5;
  localparam logic [2:0] STEP_SELFCHECK  = 3'h6;
  localparam logic [2:0] STEP_NONE       = 3'h7;
  localparam logic [1:0] MANDATORY_MASK  = 2'h3;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h01;
  typedef enum logic [1:0] {
    VCS_IDLE  = 2'b00,
    VCS_SYNC  = 2'b01,
    VCS_STEP  = 2'b10,
    VCS_CIDLE = 2'b11
  } vcs_state_t;
endpackage
`default_nettype wire

// >>> src/vcs_scheduler.sv
// voltage conversion scheduler: on-demand and cyclic routine control
// Functional notes
// - with coulomb counting on, on-demand start waits for next current conversion start
// - cell and stack steps run in every routine run
// - optional on-demand steps run only if selected in the frame that sets start
// - start bit reads one for the whole run, cleared after last step
// - further start requests are ignored while the start bit is high
// - select bits written without start do nothing
// - on-demand window length comes from the on-demand filter field
// - each result is written as soon as its own step ends
// - ready bit set on new result, cleared when its register is read
// - current alignment only holds with the shortest filter setting
// - start during override is dropped; start and select bits stay zero
// - periodic enable starts cyclic runs using the cyclic filter field
// - cyclic results without update flag leave result registers untouched
// - cyclic results with update flag are written after each step
// - programmable period timer; cycle counter increments on every expiry except one during override or in idle phase with a stop pending
// - cyclic optional step runs only when its periodicity is nonzero
// - cycle counter frozen while the period timer counts
// - expiry increments counter, restarts timer from zero and routine from the cell step
// - periodic enable rising in idle, with no start or override in the same cycle, resets timer, keeps counter, starts routine
// - periodic enable falling waits for active low, then resets both counters
// - active flag high while steps execute, low in idle time
// - only one routine execution at any moment
`default_nettype none
module vcs_scheduler
  import vcs_pkg::*;
#(
  parameter int unsigned CYCLE_UNIT_CYCLES = CYCLE_UNIT_CYC
) (
  input  wire logic                         i_clock,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_ctrl_write,
  input  wire logic                         i_wr_soc,
  input  wire logic                         i_wr_aux_input_conv_sel,
  input  wire logic                         i_wr_aux_terminal_request_bits_a_sel,
  input  wire logic                         i_wr_cell_terminal_request_bits_a_sel,
  input  wire logic                         i_wr_balance_terminal_request_bits_a_sel,
  input  wire logic                         i_wr_hardware_selfcheck_sel,
  input  wire logic                         i_wr_periodic_enable,
  input  wire logic [FILTER_W-1:0]          i_filter_ondemand,
  input  wire logic [FILTER_W-1:0]          i_filter_cyclic,
  input  wire logic [PERIOD_W-1:0]          i_cycle_period,
  input  wire logic                         i_cyclic_update,
  input  wire logic [NUM_STEPS*PER_W-1:0]   i_step_periodicity,
  input  wire logic                         i_coulomb_enable,
  input  wire logic                         i_current_conv_start,
  input  wire logic                         i_override_active,
  input  wire logic [NUM_STEPS-1:0]         i_result_read,
  output logic                              o_soc,
  output logic [NUM_STEPS-1:0]              o_step_select,
  output logic                              o_periodic_enable,
  output logic                              o_active,
  output logic [2:0]                        o_step,
  output logic [FILTER_W-1:0]               o_filter,
  output logic                              o_aligned,
  output logic [NUM_STEPS-1:0]              o_result_write,
  output logic [NUM_STEPS-1:0]              o_result_ready,
  output logic [COUNT_W-1:0]                o_cycle_counter,
  output logic [PERIOD_W-1:0]               o_cycle_period_timer
);

  // first scheduled step at or after a given index, STEP_NONE when none is left
  function automatic logic [2:0] next_step(input logic [NUM_STEPS-1:0] mask,
                                           input logic [3:0] from);
    logic [2:0] found;
    found = STEP_NONE;
    for (int i = NUM_STEPS - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= from)) begin
        found = 3'(i);
      end
    end
    return found;
  endfunction

  vcs_state_t              state_reg, state_next;
  logic                    soc_reg, soc_next;
  logic                    periodic_en_reg, periodic_en_next;
  logic                    cyc_run_reg, cyc_run_next;
  logic                    mode_od_reg, mode_od_next;
  logic                    upd_reg, upd_next;
  logic [NUM_STEPS-1:0]    mask_reg, mask_next;
  logic [2:0]              step_reg, step_next;
  logic [FILTER_W-1:0]     filt_reg, filt_next;
  logic [WIN_W-1:0]        win_cnt_reg, win_cnt_next;
  logic [PRE_W-1:0]        pre_reg, pre_next;
  logic [PERIOD_W-1:0]     timer_reg, timer_next;
  logic [COUNT_W-1:0]      count_reg, count_next;
  logic [NUM_STEPS-1:0]    wr_reg, wr_next;
  logic [NUM_STEPS-1:0]    ready_reg;
  logic                    aligned_reg, aligned_next;

  // request decode from one control frame
  wire logic                 soc_req     = i_ctrl_write && i_wr_soc && !soc_reg;
  wire logic                 soc_accept  = soc_req && !i_override_active &&
                                           state_reg == VCS_IDLE && !cyc_run_reg;
  wire logic                 cyc_rise    = i_ctrl_write && i_wr_periodic_enable &&
                                           !periodic_en_reg;
  wire logic [NUM_STEPS-1:0] od_mask     = {i_wr_hardware_selfcheck_sel,
                                            i_wr_balance_terminal_request_bits_a_sel,
                                            i_wr_cell_terminal_request_bits_a_sel,
                                            i_wr_aux_terminal_request_bits_a_sel,
                                            i_wr_aux_input_conv_sel,
                                            MANDATORY_MASK};
  wire logic [WIN_W-1:0]     win_len     = WIN_W'(STEP_BASE_CYC) << filt_reg;
  wire logic                 win_end     = win_cnt_reg == win_len - WIN_W'(1);
  wire logic [PERIOD_W-1:0]  period_eff  = (i_cycle_period == '0) ? PERIOD_RESET
                                                                  : i_cycle_period;
  wire logic                 unit_tick   = pre_reg == PRE_W'(CYCLE_UNIT_CYCLES - 1);
  wire logic                 expiry      = cyc_run_reg && unit_tick &&
                                           (timer_reg + PERIOD_W'(1) >= period_eff);
  wire logic [2:0]           step_after  = next_step(mask_reg, 4'(step_reg) + 4'h1);

  // cyclic step selection: mandatory steps always, others by periodicity
  logic [NUM_STEPS-1:0] cyc_mask;
  assign cyc_mask[1:0] = MANDATORY_MASK;
  generate
    for (genvar g = 2; g < NUM_STEPS; g++) begin : g_period
      wire logic [PER_W-1:0] per = i_step_periodicity[g*PER_W +: PER_W];
      assign cyc_mask[g] = (per != '0) && ((count_reg % COUNT_W'(per)) == '0);
    end
  endgenerate

  // sequencing; override aborts everything and locks cyclic restart
  always_comb begin
    state_next       = state_reg;
    soc_next         = soc_reg;
    periodic_en_next = periodic_en_reg;
    cyc_run_next     = cyc_run_reg;
    mode_od_next     = mode_od_reg;
    upd_next         = upd_reg;
    mask_next        = mask_reg;
    step_next        = step_reg;
    filt_next        = filt_reg;
    win_cnt_next     = win_cnt_reg;
    pre_next         = cyc_run_reg && !unit_tick ? pre_reg + PRE_W'(1) : '0;
    timer_next       = timer_reg;
    count_next       = count_reg;
    wr_next          = '0;
    aligned_next     = aligned_reg;
    if (i_ctrl_write) begin
      periodic_en_next = i_wr_periodic_enable;
    end
    if (cyc_run_reg && unit_tick) begin
      timer_next = timer_reg + PERIOD_W'(1);
    end
    if (i_override_active) begin
      state_next   = VCS_IDLE;
      soc_next     = 1'b0;
      cyc_run_next = 1'b0;
      timer_next   = '0;
    end else begin
      unique case (state_reg)
        VCS_IDLE: begin
          if (soc_accept) begin
            soc_next     = 1'b1;
            mode_od_next = 1'b1;
            mask_next    = od_mask;
            filt_next    = i_filter_ondemand;
            step_next    = STEP_CELL;
            win_cnt_next = '0;
            aligned_next = i_coulomb_enable && i_filter_ondemand == '0;
            state_next   = i_coulomb_enable ? VCS_SYNC : VCS_STEP;
          end else if (cyc_rise) begin
            cyc_run_next = 1'b1;
            timer_next   = '0;
            pre_next     = '0;
            mode_od_next = 1'b0;
            mask_next    = cyc_mask;
            filt_next    = i_filter_cyclic;
            upd_next     = i_cyclic_update;
            step_next    = STEP_CELL;
            win_cnt_next = '0;
            aligned_next = 1'b0;
            state_next   = VCS_STEP;
          end
        end
        VCS_SYNC: begin
          if (i_current_conv_start) begin
            state_next = VCS_STEP;
          end
        end
        VCS_STEP: begin
          win_cnt_next = win_cnt_reg + WIN_W'(1);
          if (win_end) begin
            if (mode_od_reg || upd_reg) begin
              wr_next[step_reg] = 1'b1;
            end
            win_cnt_next = '0;
            if (step_after == STEP_NONE) begin
              if (mode_od_reg) begin
                soc_next   = 1'b0;
                state_next = VCS_IDLE;
              end else begin
                state_next = VCS_CIDLE;
              end
            end else begin
              step_next = step_after;
            end
          end
        end
        VCS_CIDLE: begin
          if (!periodic_en_reg) begin
            cyc_run_next = 1'b0;
            timer_next   = '0;
            count_next   = '0;
            state_next   = VCS_IDLE;
          end
        end
      endcase
      // expiry restarts the routine; a stop pending in idle phase wins
      if (expiry && !(state_reg == VCS_CIDLE && !periodic_en_reg)) begin
        count_next   = count_reg + COUNT_W'(1);
        timer_next   = '0;
        mask_next    = cyc_mask;
        filt_next    = i_filter_cyclic;
        upd_next     = i_cyclic_update;
        step_next    = STEP_CELL;
        win_cnt_next = '0;
        state_next   = VCS_STEP;
      end
    end
  end

  // state and counters
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg       <= VCS_IDLE;
      soc_reg         <= 1'b0;
      periodic_en_reg <= 1'b0;
      cyc_run_reg     <= 1'b0;
      mode_od_reg     <= 1'b0;
      upd_reg         <= 1'b0;
      mask_reg        <= '0;
      step_reg        <= STEP_CELL;
      filt_reg        <= '0;
      win_cnt_reg     <= '0;
      pre_reg         <= '0;
      timer_reg       <= '0;
      count_reg       <= '0;
      wr_reg          <= '0;
      aligned_reg     <= 1'b0;
    end else begin
      state_reg       <= state_next;
      soc_reg         <= soc_next;
      periodic_en_reg <= periodic_en_next;
      cyc_run_reg     <= cyc_run_next;
      mode_od_reg     <= mode_od_next;
      upd_reg         <= upd_next;
      mask_reg        <= mask_next;
      step_reg        <= step_next;
      filt_reg        <= filt_next;
      win_cnt_reg     <= win_cnt_next;
      pre_reg         <= pre_next;
      timer_reg       <= timer_next;
      count_reg       <= count_next;
      wr_reg          <= wr_next;
      aligned_reg     <= aligned_next;
    end
  end

  // ready bits: a new result in the read cycle keeps the bit set
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_reg <= '0;
    end else begin
      ready_reg <= (ready_reg & ~i_result_read) | wr_reg;
    end
  end

  // selects read back only while an on-demand run holds them
  assign o_soc                = soc_reg;
  assign o_step_select        = soc_reg ? mask_reg : '0;
  assign o_periodic_enable    = periodic_en_reg;
  assign o_active             = state_reg == VCS_STEP || state_reg == VCS_SYNC;
  assign o_step               = step_reg;
  assign o_filter             = filt_reg;
  assign o_aligned            = aligned_reg;
  assign o_result_write       = wr_reg;
  assign o_result_ready       = ready_reg;
  assign o_cycle_counter      = count_reg;
  assign o_cycle_period_timer = timer_reg;

  // checks
  sequence s_od_start;
    soc_accept && !i_coulomb_enable;
  endsequence
  sequence s_run_end;
    state_reg == VCS_STEP && win_end && step_after == STEP_NONE;
  endsequence

  property p_sync_wait;
    @(posedge i_clock) disable iff (!i_reset_n)
      soc_accept && i_coulomb_enable |=> state_reg == VCS_SYNC && soc_reg;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync wait missing");

  property p_mandatory;
    @(posedge i_clock) disable iff (!i_reset_n)
      state_reg == VCS_STEP |-> mask_reg[1:0] == MANDATORY_MASK;
  endproperty
  a_mandatory: assert property (p_mandatory) else $error("mandatory step dropped");

  property p_od_start;
    @(posedge i_clock) disable iff (!i_reset_n)
      s_od_start |=> o_active && soc_reg && step_reg == STEP_CELL && filt_reg ==
        $past(i_filter_ondemand);
  endproperty
  a_od_start: assert property (p_od_start) else $error("on-demand start wrong");

  property p_soc_clear;
    @(posedge i_clock) disable iff (!i_reset_n)
      (s_run_end and (mode_od_reg && !i_override_active)) |=> !soc_reg && !o_active;
  endproperty
  a_soc_clear: assert property (p_soc_clear) else $error("start bit not cleared");

  property p_no_sel_only;
    @(posedge i_clock) disable iff (!i_reset_n)
      state_reg == VCS_IDLE && i_ctrl_write && !i_wr_soc && !cyc_rise && !expiry
        |=> state_reg == VCS_IDLE && !soc_reg;
  endproperty
  a_no_sel_only: assert property (p_no_sel_only) else $error("select alone started");

  property p_override;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_override_active |=> !soc_reg && !o_active && o_step_select == '0;
  endproperty
  a_override: assert property (p_override) else $error("start kept in override");

  property p_no_update;
    @(posedge i_clock) disable iff (!i_reset_n)
      state_reg == VCS_STEP && win_end && !mode_od_reg && !upd_reg |=> wr_reg == '0;
  endproperty
  a_no_update: assert property (p_no_update) else $error("cyclic result written");

  property p_ready;
    @(posedge i_clock) disable iff (!i_reset_n)
      wr_reg != '0 |=> (ready_reg & $past(wr_reg)) == $past(wr_reg);
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit not set");

  property p_expiry;
    @(posedge i_clock) disable iff (!i_reset_n)
      expiry && !i_override_active && state_reg == VCS_STEP
        |=> timer_reg == '0 && count_reg == $past(count_reg) + COUNT_W'(1) &&
            step_reg == STEP_CELL;
  endproperty
  a_expiry: assert property (p_expiry) else $error("expiry handling wrong");

  property p_stop_waits;
    @(posedge i_clock) disable iff (!i_reset_n)
      cyc_run_reg && state_reg == VCS_STEP && !win_end && !i_override_active
        |=> cyc_run_reg;
  endproperty
  a_stop_waits: assert property (p_stop_waits) else $error("stopped during active");

endmodule
`default_nettype wire

// >>> verification/vcs_far_model.sv
// far-side model: current conversion start source and result register reader
`default_nettype none
module vcs_far_model
  import vcs_pkg::*;
#(
  parameter int unsigned CUR_PERIOD = 37
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_current_enable,
  input  wire logic                 i_auto_read,
  input  wire logic [NUM_STEPS-1:0] i_ready,
  output logic                      o_current_conv_start,
  output logic      [NUM_STEPS-1:0] o_result_read
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  // free-running current acquisition; pulses only while the source is enabled
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= 0;
      o_current_conv_start <= 1'b0;
      o_result_read <= '0;
    end else begin
      cnt <= (cnt + 1 == CUR_PERIOD) ? 0 : cnt + 1;
      o_current_conv_start <= i_current_enable && (cnt == 0);
      // skip a bit just read so its ready flag has a cycle to drop
      o_result_read <= i_auto_read ? (i_ready & ~o_result_read) : '0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/voltage_conversion_scheduler_tb.sv
// self-checking bench for the voltage conversion scheduler
`default_nettype none
module voltage_conversion_scheduler_tb
  import vcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TIMEOUT = 20000;
  logic        clk, rst_n, wr, soc, pen, cupd, coul, ovr, auto_rd, cur_en, cur;
  logic [4:0]  sel;
  logic [2:0]  f_od, f_cy, step, filt;
  logic [7:0]  per, tcyc;
  logic [27:0] sp;
  logic [6:0]  rd, sel_o, wr_o, rdy, wr_seen;
  logic        o_soc, pen_o, act, aligned;
  logic [15:0] ncyc, c0;
  int unsigned fail_count, checks_done, cyc, prev_wr, gap_lo, gap_hi, n;

  vcs_scheduler #(.CYCLE_UNIT_CYCLES(20)) i_dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_ctrl_write(wr), .i_wr_soc(soc),
    .i_wr_aux_input_conv_sel(sel[0]), .i_wr_aux_terminal_request_bits_a_sel(sel[1]),
    .i_wr_cell_terminal_request_bits_a_sel(sel[2]), .i_wr_balance_terminal_request_bits_a_sel(sel[3]),
    .i_wr_hardware_selfcheck_sel(sel[4]), .i_wr_periodic_enable(pen),
    .i_filter_ondemand(f_od), .i_filter_cyclic(f_cy), .i_cycle_period(per),
    .i_cyclic_update(cupd), .i_step_periodicity(sp), .i_coulomb_enable(coul),
    .i_current_conv_start(cur), .i_override_active(ovr), .i_result_read(rd),
    .o_soc(o_soc), .o_step_select(sel_o), .o_periodic_enable(pen_o), .o_active(act),
    .o_step(step), .o_filter(filt), .o_aligned(aligned), .o_result_write(wr_o),
    .o_result_ready(rdy), .o_cycle_counter(ncyc), .o_cycle_period_timer(tcyc));

  vcs_far_model i_far (
    .i_clock(clk), .i_reset_n(rst_n), .i_current_enable(cur_en), .i_auto_read(auto_rd),
    .i_ready(rdy), .o_current_conv_start(cur), .o_result_read(rd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // write-pulse monitor on the falling edge, where the one-cycle store pulse has settled;
  // collects the stored steps and the spacing between them
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (|wr_o) begin
      wr_seen <= wr_seen | wr_o;
      if (prev_wr != 0 && cyc - prev_wr < gap_lo) gap_lo <= cyc - prev_wr;
      if (prev_wr != 0 && cyc - prev_wr > gap_hi) gap_hi <= cyc - prev_wr;
      prev_wr <= cyc;
    end
    if (cyc == TIMEOUT) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // sample one time unit after the edge so registered outputs have settled
  task automatic tick(input int unsigned k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one control frame, held for exactly one sampling edge
  task automatic frame(input logic s, input logic [4:0] m, input logic e);
    @(posedge clk);
    wr <= 1'b1;
    soc <= s;
    sel <= m;
    pen <= e;
    tick(1);
    wr <= 1'b0;
  endtask
  task automatic clr();
    wr_seen = '0;
    prev_wr = 0;
    gap_lo = 32'hffff;
    gap_hi = 0;
  endtask
  task automatic wait_idle();
    n = 0;
    while ((act !== 1'b0 || o_soc !== 1'b0) && n < 3000) begin
      tick(1);
      n++;
    end
    check("idle", {act, o_soc}, 0);
    // the last store pulse stands in the cycle where active falls; let the monitor see it
    tick(1);
  endtask
  // a step window lasts w cycles; the store pulse may add one cycle
  task automatic gap_check(input int unsigned w);
    check("gap", (gap_lo >= w && gap_hi <= w + 1), 1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {rst_n, wr, soc, pen, cupd, coul, ovr, auto_rd, cur_en, sel, f_od, f_cy, sp} = '0;
    per = 8'h14;
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    clr();
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    // on-demand run with steps 2, 4 and 6 selected
    clr();
    frame(1'b1, 5'h15, 1'b0);
    check("soc", o_soc, 1);
    check("active", act, 1);
    check("select", sel_o, 7'h57);
    check("first_step", step, 3'h0);
    tick(20);
    frame(1'b1, 5'h1f, 1'b0);
    check("select_held", sel_o, 7'h57);
    wait_idle();
    check("writes", wr_seen, 7'h57);
    gap_check(100);
    tick(2);
    check("ready", rdy, 7'h57);
    auto_rd <= 1'b1;
    tick(6);
    check("ready_clr", rdy, 7'h00);
    auto_rd <= 1'b0;
    frame(1'b0, 5'h1f, 1'b0);
    tick(3);
    check("no_start", {o_soc, act, sel_o}, 0);
    $display("test on_demand done");
    // coulomb counting: the run waits for a current conversion start
    coul <= 1'b1;
    clr();
    frame(1'b1, 5'h00, 1'b0);
    tick(300);
    check("held_act", act, 1);
    check("held_wr", wr_seen, 0);
    cur_en <= 1'b1;
    tick(60);
    check("aligned", aligned, 1);
    wait_idle();
    check("sync_wr", wr_seen, 7'h03);
    f_od <= 3'h1;
    clr();
    frame(1'b1, 5'h00, 1'b0);
    tick(80);
    check("not_aligned", aligned, 0);
    check("od_filter", filt, 3'h1);
    wait_idle();
    gap_check(200);
    coul <= 1'b0;
    cur_en <= 1'b0;
    // override blocks a start and keeps the request bits at zero
    ovr <= 1'b1;
    frame(1'b1, 5'h1f, 1'b0);
    tick(2);
    check("ovr_block", {o_soc, act, sel_o}, 0);
    ovr <= 1'b0;
    tick(1);
    $display("test sync_override done");
    // cyclic runs without register update, step 2 every cycle, step 3 disabled
    sp <= 28'h0000100;
    clr();
    frame(1'b0, 5'h00, 1'b1);
    check("cyc_act", act, 1);
    check("cyc_soc", o_soc, 0);
    check("cyc_filter", filt, 3'h0);
    check("pen_stored", pen_o, 1);
    c0 = ncyc;
    tick(100);
    check("frozen", ncyc, c0);
    frame(1'b1, 5'h00, 1'b1);
    check("od_refused", o_soc, 0);
    n = 0;
    while (ncyc === c0 && n < 600) begin
      tick(1);
      n++;
    end
    check("count_inc", ncyc, c0 + 16'h1);
    check("timer_zero", tcyc, 0);
    check("no_update", wr_seen, 0);
    tick(2);
    check("restart", act, 1);
    frame(1'b0, 5'h00, 1'b0);
    n = 0;
    while ((ncyc !== 0 || act !== 1'b0) && n < 1000) begin
      tick(1);
      n++;
    end
    check("stopped", {ncyc, tcyc, act}, 0);
    // cyclic runs with register update
    cupd <= 1'b1;
    clr();
    frame(1'b0, 5'h00, 1'b1);
    check("start_timer", {ncyc, tcyc}, 0);
    n = 0;
    while (ncyc !== 16'h1 && n < 600) begin
      tick(1);
      n++;
    end
    check("upd_writes", wr_seen, 7'h07);
    frame(1'b0, 5'h00, 1'b0);
    wait_idle();
    $display("test cyclic done");
    report_and_stop();
  end
endmodule
`default_nettype wire
